//--- hw/pin_sync.sv
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes pin levels are asynchronous to clk.
 */
`timescale 1ns/10ps

module pin_sync #(
    parameter int WIDTH = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

//--- hw/six_bit_port_io.sv
/*
 * Six-bit general-purpose port with output latch, pin-level and
 * direction registers, reached as an AHB-Lite slave.
 * Assumes one master, single word transfers, and board logic that
 * resolves each pin from pin_out and pin_oe.
 */
`timescale 1ns/10ps
`include "six_bit_port_io_map.svh"

module six_bit_port_io #(
    parameter int PINS = `PORT_PINS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe
);

    logic [PINS-1:0] pin_value_bits;
    logic [PINS-1:0] output_latch;
    logic [PINS-1:0] pin_direction;
    logic wr_pending;
    six_bit_port_io_pkg::reg_sel_t wr_sel;
    six_bit_port_io_pkg::reg_sel_t next_sel;
    logic [`PORT_ADDR_W-1:0] word_idx;
    logic addr_take;
    logic [PINS-1:0] wr_data;
    logic [PINS-1:0] next_direction;
    logic [PINS-1:0] rd_data;
    logic [PINS-1:0] dir_fixed;
    logic wr_dir_hit;
    logic wr_latch_hit;

    pin_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pin_value_bits)
    );

    // Address phase decode; printed offsets are word indices
    assign word_idx = haddr[`PORT_ADDR_W+1:2];
    assign addr_take = hsel && hready && htrans == `PORT_HTRANS_NONSEQ;
    assign next_sel =
        word_idx == `PORT_IDX_PIN_LEVEL ? six_bit_port_io_pkg::sel_pin_level :
        word_idx == `PORT_IDX_DIRECTION ? six_bit_port_io_pkg::sel_direction :
        word_idx == `PORT_IDX_LATCH ? six_bit_port_io_pkg::sel_latch :
        six_bit_port_io_pkg::sel_none;

    assign hreadyout = 1'h1;
    assign hresp = `PORT_HRESP_OKAY;

    // Input-only pin has its direction forced high
    assign dir_fixed = PINS'(1) << `PORT_INPUT_ONLY_BIT;
    assign wr_data = hwdata[PINS-1:0];
    assign next_direction = wr_data | dir_fixed;

    // Data-phase write strobes; pin-level writes land in the latch
    assign wr_dir_hit = wr_pending &&
        wr_sel == six_bit_port_io_pkg::sel_direction;
    assign wr_latch_hit = wr_pending &&
        (wr_sel == six_bit_port_io_pkg::sel_latch ||
         wr_sel == six_bit_port_io_pkg::sel_pin_level);

    // Read mux; upper bits of the word stay zero
    always_comb begin
        case (next_sel)
            six_bit_port_io_pkg::sel_pin_level: rd_data = pin_value_bits;
            six_bit_port_io_pkg::sel_direction: rd_data = pin_direction;
            six_bit_port_io_pkg::sel_latch: rd_data = output_latch;
            default: rd_data = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pending <= 1'h0;
            wr_sel <= six_bit_port_io_pkg::sel_none;
        end else begin
            wr_pending <= addr_take && hwrite;
            wr_sel <= next_sel;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= '0;
        end else if (addr_take && !hwrite) begin
            hrdata <= {{(32-PINS){1'h0}}, rd_data};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_direction <= `PORT_DIR_RESET;
        end else if (wr_dir_hit) begin
            pin_direction <= next_direction;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            output_latch <= `PORT_LATCH_RESET;
        end else if (wr_latch_hit) begin
            output_latch <= wr_data;
        end
    end

    // Drive pins whose direction bit is zero
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            pin_out <= output_latch;
            pin_oe <= ~pin_direction;
        end
    end

endmodule

//--- include/six_bit_port_io_map.svh
/*
 * Register map, field layout and reset values of the six-bit port.
 * Assumes a 32-bit AHB-Lite slave with byte addresses.
 */
`ifndef SIX_BIT_PORT_IO_MAP_SVH
`define SIX_BIT_PORT_IO_MAP_SVH

`define PORT_IDX_PIN_LEVEL 12'h00c
`define PORT_IDX_DIRECTION 12'h08c
`define PORT_IDX_LATCH 12'h10c
`define PORT_ADDR_W 12
`define PORT_REG_W 8
`define PORT_PINS 6
`define PORT_INPUT_ONLY_BIT 3
`define PORT_DIR_RESET 6'h3f
`define PORT_LATCH_RESET 6'h00
`define PORT_HTRANS_NONSEQ 2'h2
`define PORT_HSIZE_WORD 3'h2
`define PORT_HRESP_OKAY 1'h0

`endif

//--- include/six_bit_port_io_pkg.sv
/*
 * Types shared by the six-bit port design files.
 * Assumes the map header for numeric values.
 */
package six_bit_port_io_pkg;

    typedef enum logic [1:0] {
        sel_none,
        sel_pin_level,
        sel_direction,
        sel_latch
    } reg_sel_t;

endpackage

//--- sim/pin_board.sv
/* Board pins: driven pins echo the port, others follow ext. */
`timescale 1ns/10ps
module pin_board (input wire logic [5:0] pin_out, pin_oe, ext,
    output logic [5:0] pin_in);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

//--- sim/six_bit_port_io_monitor.sv
/* Port checker; sees only the ports of the port it is bound to. */
`timescale 1ns/10ps
module six_bit_port_io_monitor (
    input wire logic clk, rst, hsel, hwrite,
    input wire logic [31:0] haddr, hwdata, hrdata,
    input wire logic [1:0] htrans,
    input wire logic [5:0] pin_in, pin_out, pin_oe);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire rd = hsel && htrans == 2'h2 && !hwrite;
    wire wr = hsel && htrans == 2'h2 && hwrite;
    a_pin_read: assert property (rd && haddr == 32'h30
        && !$past(rst) && !$past(rst, 2) && $stable(pin_in)
        && $past(pin_in) == $past(pin_in, 2)
        |=> hrdata[5:0] == $past(pin_in)) else $error("pin");
    a_latch_pins: assert property (wr && (haddr | 32'h400) == 32'h430
        |-> ##3 pin_out == 6'($past(hwdata, 2))) else $error("lat");
    a_dir_drive: assert property (wr && haddr == 32'h230
        |-> ##3 pin_oe == (~6'($past(hwdata, 2)) & 6'h37)) else $error("dir");
    a_dir_three: assert property (rd && haddr == 32'h230
        |=> hrdata[3]) else $error("d3");
    a_top_zero: assert property (hrdata[31:6] == 26'h0) else $error("t");
    a_reset_in: assert property ($fell(rst) |-> pin_oe == 6'h0)
        else $error("rst");
    a_out_cause: assert property ($changed(pin_out) && !$past(rst)
        |-> $past(wr, 3)) else $error("out");
    cover property (rd && haddr == 32'h30);
    cover property (wr && haddr == 32'h230);
    cover property (wr && haddr == 32'h430);
endmodule
bind six_bit_port_io six_bit_port_io_monitor mon (.*);

//--- sim/six_bit_port_io_tb.sv
/* Random port traffic through the board model; hreadyout is hready. */
`timescale 1ns/10ps
module six_bit_port_io_tb;
    logic clk = 0, rst = 1, hwrite = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, s = 32'h3703;
    logic [5:0] ext = '0, pin_in, pin_out, pin_oe, dir, lat;
    wire hready;
    int err_count = 0, checks_done = 0;
    always #2.5 clk = ~clk;
    pin_board board (.*);
    six_bit_port_io dut (.*, .hsel(1'b1), .hsize(3'h2),
        .hreadyout(hready), .hresp());
    function logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task xfer(input logic w, input logic [31:0] a, d, input logic [5:0] e);
        {hwrite, haddr, htrans} <= {w, a, 2'h2};
        do @(posedge clk); while (hready !== 1'b1);
        {htrans, hwdata} <= {2'h0, d};
        do @(posedge clk); while (hready !== 1'b1);
        checks_done += !w;
        if (!w && hrdata !== {26'h0, e}) begin
            err_count++;
            $display("[FAIL] %0t %h %h", $time, hrdata, e);
        end
    endtask
    task results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, 32'h230, '0, 6'h3f);
        for (int i = 0; i < 40; i++) begin
            s = xs(s);
            if (i == 0) s = 32'hffffffc0;
            {ext, lat, dir} <= {s[21:16], s[13:8], s[5:0] | 6'h08};
            xfer(1'b1, 32'h230, s, '0);
            xfer(1'b1, 32'h30, s >> 8, '0);
            xfer(1'b0, 32'h430, '0, lat);
            xfer(1'b0, 32'h230, '0, dir);
            xfer(1'b0, 32'h30, '0, (~dir & lat) | (dir & ext));
        end
        results();
    end
endmodule
